// >>> hw/link_quality_monitor.sv
// Link quality status and diagnostic register bank
`include "link_quality_monitor_map.svh"

module link_quality_monitor (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire link_quality_monitor_pkg::reg_req_s i_req,
   input wire link_quality_monitor_pkg::link_status_s i_link,
   output logic [15:0] o_rdata,
   output logic o_irq
);
   import link_quality_monitor_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Input synchronisers for link-side status
   link_status_s sync1_ff;
   link_status_s sync2_ff;
   link_status_s prev_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff <= '0;
      end else begin
         sync1_ff <= i_link;
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   link_status_s st;
   assign st = sync2_ff;

   wire train_evt = st.train_done & ~prev_ff.train_done;
   wire loss_evt = st.link_loss & ~prev_ff.link_loss;
   wire fail_evt = st.link_fail & ~prev_ff.link_fail;

   ////////////////////////////////////////////////////////////////////////
   // Address decode
   wire wr_latch = i_req.wr && i_req.addr == `LQM_OFS_LATCH;
   wire wr_clr = i_req.wr && i_req.addr == `LQM_OFS_IRQ_CLR;
   wire wr_en = i_req.wr && i_req.addr == `LQM_OFS_IRQ_EN;

   ////////////////////////////////////////////////////////////////////////
   // Timing fields, held until the next completed training; polarity and ready follow each cycle
   logic [7:0] train_ms_ff;
   logic [7:0] remote_ms_ff;
   logic [7:0] local_ms_ff;
   logic pol_ff;
   logic ready_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         train_ms_ff <= 8'h00;
         remote_ms_ff <= 8'h00;
         local_ms_ff <= 8'h00;
         pol_ff <= 1'b0;
         ready_ff <= 1'b0;
      end else begin
         pol_ff <= st.rx_pol_inv;
         ready_ff <= st.comm_ready;
         if (train_evt) begin
            train_ms_ff <= st.train_ms;
            remote_ms_ff <= st.remote_ms;
            local_ms_ff <= st.local_ms;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Latched link-drop indicators
   logic [`LQM_LATCH_W-1:0] latch_ff;
   logic [`LQM_LATCH_W-1:0] nxt_latch;
   logic [`LQM_LATCH_W-1:0] lat_evt;
   logic [`LQM_LATCH_W-1:0] lat_low;
   logic [`LQM_LATCH_W-1:0] wr_zero;

   // Event per bit: low-latch bits see the level dropping
   assign lat_evt[`LQM_LAT_CHAN] = ~st.chan_good;
   assign lat_evt[`LQM_LAT_INH] = st.fail_inhibit;
   assign lat_evt[`LQM_LAT_SIG] = st.sig_detect;
   assign lat_evt[`LQM_LAT_FER] = st.frame_err_rate;
   assign lat_evt[`LQM_LAT_BLK] = ~st.block_sync;
   assign lat_evt[`LQM_LAT_WDG] = ~st.medium_wdog;
   assign lat_low = `LQM_LATCH_LOW;
   assign wr_zero = {`LQM_LATCH_W{wr_latch}} & ~i_req.wdata[5:0];

   genvar gi;
   generate
      for (gi = 0; gi < `LQM_LATCH_W; gi++) begin : g_lat
         // Event wins over a concurrent software write
         if (gi == `LQM_LAT_CHAN) begin : g_ll_clr
            // Zero write clears; drop also forces zero
            assign nxt_latch[gi] = (lat_evt[gi] || wr_zero[gi]) ? 1'b0 :
               latch_ff[gi];
         end else if (gi == `LQM_LAT_BLK || gi == `LQM_LAT_WDG) begin : g_ll
            assign nxt_latch[gi] = lat_evt[gi] ? 1'b0 :
               (wr_zero[gi] ? 1'b1 : latch_ff[gi]);
         end else begin : g_lh
            assign nxt_latch[gi] = lat_evt[gi] ? 1'b1 :
               (wr_zero[gi] ? 1'b0 : latch_ff[gi]);
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         latch_ff <= `LQM_LATCH_RST;
      end else begin
         latch_ff <= nxt_latch;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Saturating event counters
   logic [5:0] loss_cnt_ff;
   logic [9:0] fail_cnt_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         loss_cnt_ff <= 6'h00;
         fail_cnt_ff <= 10'h000;
      end else begin
         if (loss_evt && loss_cnt_ff != `LQM_LOSS_MAX) begin
            loss_cnt_ff <= loss_cnt_ff + 6'h01;
         end
         if (fail_evt && !st.link_loss && fail_cnt_ff != `LQM_FAIL_MAX) begin
            fail_cnt_ff <= fail_cnt_ff + 10'h001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status, clear and enable
   logic [`LQM_IRQ_W-1:0] irq_stat_ff;
   logic [`LQM_IRQ_W-1:0] irq_en_ff;
   logic [`LQM_IRQ_W-1:0] irq_set;
   logic irq_ff;

   assign irq_set[`LQM_IRQ_TRAIN] = train_evt;
   assign irq_set[`LQM_IRQ_LOSS] = loss_evt;
   assign irq_set[`LQM_IRQ_FAIL] = fail_evt && !st.link_loss;
   // Hardware change only: low bits drop from one, high bits rise from zero
   assign irq_set[`LQM_IRQ_LATCH] = |(lat_evt & (latch_ff ^ ~lat_low));

   wire [`LQM_IRQ_W-1:0] irq_clr =
      {`LQM_IRQ_W{wr_clr}} & i_req.wdata[`LQM_IRQ_W-1:0];
   wire [`LQM_IRQ_W-1:0] nxt_irq_stat = irq_set | (irq_stat_ff & ~irq_clr);
   wire [`LQM_IRQ_W-1:0] nxt_irq_en =
      wr_en ? i_req.wdata[`LQM_IRQ_W-1:0] : irq_en_ff;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         irq_stat_ff <= '0;
         irq_en_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         irq_stat_ff <= nxt_irq_stat;
         irq_en_ff <= nxt_irq_en;
         irq_ff <= |(nxt_irq_stat & nxt_irq_en);
      end
   end

   assign o_irq = irq_ff;

   ////////////////////////////////////////////////////////////////////////
   // Read data, registered one cycle after the strobe
   logic [15:0] rd_mux;
   logic [15:0] rdata_ff;

   always_comb begin
      rd_mux = 16'h0000;
      case (i_req.addr)
         `LQM_OFS_POLARITY: rd_mux[`LQM_POL_BIT] = pol_ff;
         `LQM_OFS_TRAIN: rd_mux[7:0] = train_ms_ff;
         `LQM_OFS_READY: rd_mux = {remote_ms_ff, local_ms_ff};
         `LQM_OFS_LATCH: rd_mux[5:0] = latch_ff;
         `LQM_OFS_COUNTS: rd_mux = {loss_cnt_ff, fail_cnt_ff};
         `LQM_OFS_PEER: rd_mux[0] = ready_ff;
         `LQM_OFS_IRQ_STAT: rd_mux[`LQM_IRQ_W-1:0] = irq_stat_ff;
         `LQM_OFS_IRQ_EN: rd_mux[`LQM_IRQ_W-1:0] = irq_en_ff;
         default: rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_ff <= 16'h0000;
      end else begin
         rdata_ff <= i_req.rd ? rd_mux : 16'h0000;
      end
   end

   assign o_rdata = rdata_ff;
endmodule

// >>> pkg/link_quality_monitor_map.svh
// Register offsets, field positions, reset values of the link quality monitor
// Notes on behaviour
// - Bit 12 of polarity status shows received polarity, one when inverted.
// - Training time in ms, read-only, bits 7..0, resets to zero.
// - Remote receiver time in ms, read-only, bits 15..8 of ready times.
// - Local receiver time in ms, read-only, bits 7..0 of ready times.
// - Bit 5 latches low when channel good drops; writing zero clears it.
// - Bit 4 latches high on fail inhibit; writing zero clears it.
// - Bit 3 latches high on signal detect; writing zero clears it.
// - Bit 2 latches high on high frame error rate; writing zero clears.
// - Bit 1 latches low on block lock loss; writing zero sets it.
// - Bit 0 latches low on medium watchdog low; writing zero sets it.
// - Six-bit link loss count at bits 15..10 since power-up.
// - Ten-bit link fail without loss count at bits 9..0.
// - Communication ready flag in bit 0, other bits read zero.
`ifndef LINK_QUALITY_MONITOR_MAP_SVH
`define LINK_QUALITY_MONITOR_MAP_SVH

`define LQM_ADDR_W 11
`define LQM_OFS_POLARITY 11'h52B
`define LQM_OFS_TRAIN 11'h543
`define LQM_OFS_READY 11'h544
`define LQM_OFS_LATCH 11'h545
`define LQM_OFS_COUNTS 11'h547
`define LQM_OFS_PEER 11'h548
`define LQM_OFS_IRQ_STAT 11'h560
`define LQM_OFS_IRQ_CLR 11'h561
`define LQM_OFS_IRQ_EN 11'h562

`define LQM_POL_BIT 12
`define LQM_LAT_CHAN 5
`define LQM_LAT_INH 4
`define LQM_LAT_SIG 3
`define LQM_LAT_FER 2
`define LQM_LAT_BLK 1
`define LQM_LAT_WDG 0
`define LQM_LATCH_W 6
`define LQM_LATCH_RST 6'h00
`define LQM_LATCH_LOW 6'h23
`define LQM_LOSS_MAX 6'h3F
`define LQM_FAIL_MAX 10'h3FF
`define LQM_IRQ_W 4
`define LQM_IRQ_TRAIN 0
`define LQM_IRQ_LOSS 1
`define LQM_IRQ_FAIL 2
`define LQM_IRQ_LATCH 3

`endif

// >>> pkg/link_quality_monitor_pkg.sv
// Types shared by the link quality monitor
package link_quality_monitor_pkg;
   typedef logic [15:0] word_t;
   typedef logic [10:0] addr_t;

   typedef struct packed {
      logic rx_pol_inv;
      logic train_done;
      logic [7:0] train_ms;
      logic [7:0] remote_ms;
      logic [7:0] local_ms;
      logic chan_good;
      logic fail_inhibit;
      logic sig_detect;
      logic frame_err_rate;
      logic block_sync;
      logic medium_wdog;
      logic link_loss;
      logic link_fail;
      logic comm_ready;
   } link_status_s;

   typedef struct packed {
      logic wr;
      logic rd;
      addr_t addr;
      word_t wdata;
   } reg_req_s;
endpackage

// >>> test/link_quality_monitor_properties.sv
// Port checker for the link quality monitor
`include "link_quality_monitor_map.svh"
module link_quality_monitor_properties (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire link_quality_monitor_pkg::reg_req_s i_req,
   input wire link_quality_monitor_pkg::link_status_s i_link,
   input wire logic [15:0] o_rdata,
   input wire logic o_irq
);
   timeunit 1ns;
   timeprecision 100ps;
   import link_quality_monitor_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   wire rd_pol = i_req.rd && i_req.addr == `LQM_OFS_POLARITY;
   wire rd_train = i_req.rd && i_req.addr == `LQM_OFS_TRAIN;
   wire rd_latch = i_req.rd && i_req.addr == `LQM_OFS_LATCH;
   wire rd_peer = i_req.rd && i_req.addr == `LQM_OFS_PEER;
   wire wr_zero_low = i_req.wr && i_req.addr == `LQM_OFS_LATCH &&
      i_req.wdata[1:0] == 2'h0;
   wire low_healthy = i_link.block_sync && i_link.medium_wdog;
   a_idle_rdata_zero: assert property (!i_req.rd |=> o_rdata == 16'h0000)
      else $error("read data not zero outside a read");
   a_pol_spare_zero: assert property (rd_pol |=>
      {o_rdata[15:13], o_rdata[11:0]} == 15'h0000) else $error("pol spare");
   a_pol_follows: assert property (
      i_link.rx_pol_inv [*4] ##0 rd_pol |=> o_rdata[12])
      else $error("polarity bit not shown");
   a_train_upper_zero: assert property (rd_train |=>
      o_rdata[15:8] == 8'h00) else $error("training upper byte set");
   a_latch_upper_zero: assert property (rd_latch |=>
      o_rdata[15:6] == 10'h000) else $error("latch upper bits set");
   a_inhibit_latched: assert property (
      i_link.fail_inhibit [*4] ##0 rd_latch |=> o_rdata[4])
      else $error("inhibit not latched");
   a_chan_drop_shown: assert property (
      !i_link.chan_good [*4] ##0 rd_latch |=> !o_rdata[5])
      else $error("channel drop lost");
   a_peer_upper_zero: assert property (rd_peer |=>
      o_rdata[15:1] == 15'h0000) else $error("ready spare bits set");
   a_ready_follows: assert property (
      i_link.comm_ready [*4] ##0 rd_peer |=> o_rdata[0])
      else $error("ready flag not shown");
   a_zero_write_sets: assert property (
      low_healthy [*4] ##0 wr_zero_low ##1 (low_healthy && !i_req.wr) ##1
      (low_healthy && rd_latch) |=> o_rdata[1:0] == 2'h3)
      else $error("zero write did not set low latches");
endmodule
bind link_quality_monitor link_quality_monitor_properties
   u_link_quality_monitor_properties (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_req(i_req), .i_link(i_link), .o_rdata(o_rdata), .o_irq(o_irq));

// >>> test/link_peer_model.sv
// Behavioural far-side link logic feeding the monitor
module link_peer_model (
   input wire logic i_clk,
   output link_quality_monitor_pkg::link_status_s o_link
);
   timeunit 1ns;
   timeprecision 100ps;
   import link_quality_monitor_pkg::*;
   initial begin
      o_link = '0;
      o_link.chan_good = 1'b1;
      o_link.block_sync = 1'b1;
      o_link.medium_wdog = 1'b1;
   end
   // Change lands on an edge, then stands for hold cycles
   task automatic apply(input link_status_s v, input int hold);
      @(posedge i_clk);
      o_link <= v;
      repeat (hold) @(posedge i_clk);
   endtask
endmodule

// >>> test/tb.sv
// Self-checking bench for the link quality monitor
`include "link_quality_monitor_map.svh"
`define CHK(nm, got, exp) begin compares++; if ((got) !== (exp)) begin \
   fail_count++; $display("ERROR %s exp %h got %h", nm, exp, got); \
end end
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   import link_quality_monitor_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   reg_req_s req = '0;
   link_status_s link, base, lk;
   logic [15:0] rdata;
   logic irq;
   int fail_count = 0;
   int compares = 0;
   addr_t regs[9] = '{`LQM_OFS_POLARITY, `LQM_OFS_TRAIN, `LQM_OFS_READY,
      `LQM_OFS_LATCH, `LQM_OFS_COUNTS, `LQM_OFS_PEER, `LQM_OFS_IRQ_STAT,
      `LQM_OFS_IRQ_EN, 11'h7FF};
   always #12.5 i_clk = ~i_clk;
   link_quality_monitor u_link_quality_monitor (.i_clk(i_clk),
      .i_rst_n(i_rst_n), .i_req(req), .i_link(link), .o_rdata(rdata),
      .o_irq(irq));
   link_peer_model u_link_peer_model (.i_clk(i_clk), .o_link(link));
   task automatic wr(input addr_t a, input word_t d);
      @(posedge i_clk);
      req <= '{1'b1, 1'b0, a, d};
      @(posedge i_clk);
      req <= '0;
   endtask
   task automatic rd(input addr_t a, input word_t e);
      @(posedge i_clk);
      req <= '{1'b0, 1'b1, a, 16'h0000};
      @(posedge i_clk);
      req <= '0;
      #1;
      `CHK($sformatf("reg %h", a), rdata, e)
   endtask
   task automatic conclude();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge i_clk);
      fail_count++;
      conclude();
   end
   initial begin
      repeat (20) @(posedge i_clk);
      i_rst_n <= 1'b1;
      base = link;
      wr(`LQM_OFS_TRAIN, 16'hFFFF);
      wr(11'h7FF, 16'hFFFF);
      wr(`LQM_OFS_IRQ_STAT, 16'hFFFF);
      foreach (regs[i]) rd(regs[i], 16'h0000);
      wr(`LQM_OFS_LATCH, 16'h0000);
      rd(`LQM_OFS_LATCH, 16'h0003);
      lk = base;
      lk.train_ms = 8'h5A;
      lk.remote_ms = 8'hC3;
      lk.local_ms = 8'h3C;
      u_link_peer_model.apply(lk, 4);
      lk.train_done = 1'b1;
      u_link_peer_model.apply(lk, 5);
      lk.rx_pol_inv = 1'b1;
      lk.comm_ready = 1'b1;
      lk.train_ms = 8'h11;
      u_link_peer_model.apply(lk, 5);
      rd(`LQM_OFS_TRAIN, 16'h005A);
      rd(`LQM_OFS_READY, 16'hC33C);
      rd(`LQM_OFS_POLARITY, 16'h1000);
      rd(`LQM_OFS_PEER, 16'h0001);
      base = lk;
      lk.fail_inhibit = 1'b1;
      lk.sig_detect = 1'b1;
      lk.frame_err_rate = 1'b1;
      lk.chan_good = 1'b0;
      lk.block_sync = 1'b0;
      lk.medium_wdog = 1'b0;
      u_link_peer_model.apply(lk, 4);
      rd(`LQM_OFS_LATCH, 16'h001C);
      wr(`LQM_OFS_LATCH, 16'h0000);
      rd(`LQM_OFS_LATCH, 16'h001C);
      u_link_peer_model.apply(base, 4);
      rd(`LQM_OFS_LATCH, 16'h001C);
      wr(`LQM_OFS_LATCH, 16'h0000);
      rd(`LQM_OFS_LATCH, 16'h0003);
      for (int i = 0; i < 66; i++) begin
         lk = base;
         lk.link_loss = !(i == 3 || i == 4);
         lk.link_fail = (i >= 2 && i <= 4);
         u_link_peer_model.apply(lk, 4);
         u_link_peer_model.apply(base, 4);
         if (i == 4) rd(`LQM_OFS_COUNTS, 16'h0C02);
      end
      rd(`LQM_OFS_COUNTS, 16'hFC02);
      wr(`LQM_OFS_IRQ_EN, 16'h0002);
      rd(`LQM_OFS_IRQ_EN, 16'h0002);
      `CHK("irq raised", irq, 1'b1)
      rd(`LQM_OFS_IRQ_STAT, 16'h000F);
      wr(`LQM_OFS_IRQ_EN, 16'h0000);
      rd(`LQM_OFS_IRQ_EN, 16'h0000);
      `CHK("irq masked", irq, 1'b0)
      wr(`LQM_OFS_IRQ_EN, 16'h0002);
      wr(`LQM_OFS_IRQ_CLR, 16'h0002);
      rd(`LQM_OFS_IRQ_STAT, 16'h000D);
      `CHK("irq cleared", irq, 1'b0)
      wr(`LQM_OFS_IRQ_EN, 16'h000D);
      rd(`LQM_OFS_IRQ_EN, 16'h000D);
      `CHK("irq other bits", irq, 1'b1)
      wr(`LQM_OFS_IRQ_CLR, 16'hFFFF);
      rd(`LQM_OFS_IRQ_STAT, 16'h0000);
      `CHK("irq all cleared", irq, 1'b0)
      conclude();
   end
endmodule
